/* File: verilog/cse_pkg.sv */
// Constants for the socket change register bank
package cse_pkg;
    // Socket register offsets, relative to the socket base address
    localparam logic [5:0] OFF_FLAGS = 6'h00;
    localparam logic [5:0] OFF_ENABLES = 6'h04;
    localparam logic [5:0] OFF_STATE = 6'h08;
    localparam logic [5:0] OFF_INJECT = 6'h0C;
    localparam logic [5:0] OFF_CONTROL = 6'h10;
    localparam logic [5:0] OFF_RSVD_LO = 6'h14;
    localparam logic [5:0] OFF_RSVD_HI = 6'h1C;
    localparam logic [5:0] OFF_POWER = 6'h20;
    // Configuration offset of the socket base address register
    localparam logic [7:0] CFG_SOCKET_BAR = 8'h10;
    // Flag and enable field positions
    localparam int BIT_CSTS = 0;
    localparam int BIT_CD1 = 1;
    localparam int BIT_CD2 = 2;
    localparam int BIT_PWR = 3;
    localparam int FLAG_W = 4;
    // Present-state field positions
    localparam int ST_CSTS = 0;
    localparam int ST_CD1 = 1;
    localparam int ST_CD2 = 2;
    localparam int ST_PWR = 3;
    localparam int ST_CBCARD = 5;
    localparam int ST_16CARD = 4;
    localparam int ST_3VSOCK = 29;
    localparam int ST_5VSOCK = 28;
    // Reset values
    localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
    localparam logic [3:0] RST_ENABLES = 4'h0;
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_POWER = 32'h0000_0000;
    // Card detect enable pair value that arms detect events
    localparam logic [1:0] DETECT_EN_ON = 2'h3;
    localparam logic [1:0] DETECT_EN_OFF = 2'h0;
    // Kind of card in the socket
    typedef enum logic [1:0] {
        CSE_CARD_NONE,
        CSE_CARD_CB,
        CSE_CARD_16
    } cse_card_e;
endpackage : cse_pkg

/* File: verilog/cse_change_detect.sv */
// Change detector for the monitored socket status lines
`timescale 1ns/100ps
`default_nettype none
module cse_change_detect (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic card_status_change_signal,
    input wire logic detect_one_status,
    input wire logic detect_two_status,
    input wire logic power_cycle_status,
    input wire logic cardbus_card,
    input wire logic rearm,
    output logic [3:0] change_pulse
);
    logic csts_q;
    logic cd1_q;
    logic cd2_q;
    logic pwr_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            csts_q <= 1'b0;
            cd1_q <= 1'b0;
            cd2_q <= 1'b0;
            pwr_q <= 1'b0;
        end else if (rearm) begin
            // Forget history so a steady asserted level reports again
            csts_q <= 1'b0;
            cd1_q <= 1'b0;
            cd2_q <= 1'b0;
            pwr_q <= 1'b0;
        end else begin
            csts_q <= card_status_change_signal;
            cd1_q <= detect_one_status;
            cd2_q <= detect_two_status;
            pwr_q <= power_cycle_status;
        end
    end

    always_comb begin
        // RULE14 CardBus rising edge
        // RULE15 16-bit both edges
        if (cardbus_card) begin
            change_pulse[cse_pkg::BIT_CSTS] = card_status_change_signal & ~csts_q;
        end else begin
            change_pulse[cse_pkg::BIT_CSTS] = card_status_change_signal ^ csts_q;
        end
        // RULE13 first detect change
        change_pulse[cse_pkg::BIT_CD1] = detect_one_status ^ cd1_q;
        // RULE12 second detect change
        change_pulse[cse_pkg::BIT_CD2] = detect_two_status ^ cd2_q;
        // RULE11 power cycle change
        change_pulse[cse_pkg::BIT_PWR] = power_cycle_status ^ pwr_q;
    end
endmodule : cse_change_detect
`default_nettype wire

/* File: verilog/cse_socket_regs.sv */
// Socket register bank: change flags, enables, state, inject, control, power
//
// Operation
// RULE1 - Five 32-bit registers behind socket base
// RULE2 - Decode fixed offsets from socket base
// RULE3 - Extra power control register at 20h
// RULE4 - PME selects which reset clears context
// RULE5 - Flags mark change only, state separate
// RULE6 - Write one clears flag, zero keeps
// RULE7 - Inject write sets matching flag
// RULE8 - Bus reset clears, rearm after card reset
// RULE9 - Software clears flags before enabling interrupts
// RULE10 - Flag bits 31 to 4 read zero
// RULE11 - Power cycle change sets bit 3
// RULE12 - Second detect change sets bit 2
// RULE13 - First detect change sets bit 1
// RULE14 - CardBus card: rising edge sets bit 0
// RULE15 - 16-bit card: both edges set bit 0
// RULE16 - Enables gate interrupt, never the flags
// RULE17 - Detect enable active only at 11
// RULE18 - Interrupt while enabled flag stands
`timescale 1ns/100ps
`default_nettype none
module cse_socket_regs #(
    parameter int ADDR_W = 6
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic global_reset_n,
    input wire logic bus_reset_n,
    input wire logic pme_enable,
    input wire logic card_reset_release,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_be,
    input wire logic card_status_change_signal,
    input wire logic detect_one_status,
    input wire logic detect_two_status,
    input wire logic power_cycle_status,
    input wire logic cardbus_card,
    input wire logic pc16_card,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic status_change_interrupt,
    output logic [31:0] control_out,
    output logic [31:0] power_out
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    initial begin
        if (ADDR_W < 6) begin
            $error("ADDR_W must reach offset 20h");
        end
        if (ADDR_W > 32) begin
            $error("ADDR_W wider than a bus address");
        end
        if (cse_pkg::FLAG_W != 4) begin
            $error("Flag logic is built for four flags");
        end
        if (cse_pkg::BIT_CD2 != cse_pkg::BIT_CD1 + 1) begin
            $error("Detect enable pair must be adjacent");
        end
        if (cse_pkg::BIT_PWR >= cse_pkg::FLAG_W) begin
            $error("Flag position out of range");
        end
        if (cse_pkg::OFF_POWER <= cse_pkg::OFF_RSVD_HI) begin
            $error("Power register overlaps reserved range");
        end
        if (cse_pkg::ST_CBCARD >= cse_pkg::ST_5VSOCK) begin
            $error("Card type bits overlap socket bits");
        end
        if (cse_pkg::ST_16CARD == cse_pkg::ST_CBCARD) begin
            $error("Card type bits must differ");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off[5:2]));
    endfunction : hit

    function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [5:0] lo,
                                      input logic [5:0] hi);
        in_range = (a[ADDR_W-1:2] >= (ADDR_W-2)'(lo[5:2])) &&
                   (a[ADDR_W-1:2] <= (ADDR_W-2)'(hi[5:2]));
    endfunction : in_range

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    logic wr_en;
    logic rd_en;
    logic [31:0] wmask;
    logic context_clear;
    logic bus_clear;
    logic [3:0] change_pulse;
    logic [3:0] inject_set;
    logic [3:0] w1c_clear;

    // RULE1 memory space access
    assign wr_en = reg_sel & reg_wr;
    assign rd_en = reg_sel & reg_rd;
    assign wmask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};

    ////////////////////////////////////////////////////////////////////////
    // Reset sources

    // RULE4 PME chooses reset source
    assign context_clear = ~global_reset_n | (~pme_enable & ~bus_reset_n);
    // RULE8 bus reset clears flags
    assign bus_clear = ~bus_reset_n | ~global_reset_n;

    ////////////////////////////////////////////////////////////////////////
    // Register selects

    logic sel_flags;
    logic sel_enables;
    logic sel_state;
    logic sel_inject;
    logic sel_control;
    logic sel_rsvd;
    logic sel_power;
    logic wr_flags;
    logic wr_enables;
    logic wr_inject;
    logic wr_control;
    logic wr_power;

    // RULE2 one select per offset
    assign sel_flags = hit(reg_addr, cse_pkg::OFF_FLAGS);
    assign sel_enables = hit(reg_addr, cse_pkg::OFF_ENABLES);
    assign sel_state = hit(reg_addr, cse_pkg::OFF_STATE);
    assign sel_inject = hit(reg_addr, cse_pkg::OFF_INJECT);
    assign sel_control = hit(reg_addr, cse_pkg::OFF_CONTROL);
    assign sel_rsvd = in_range(reg_addr, cse_pkg::OFF_RSVD_LO, cse_pkg::OFF_RSVD_HI);
    assign sel_power = hit(reg_addr, cse_pkg::OFF_POWER);

    // Writes land only on writable registers
    assign wr_flags = wr_en & sel_flags;
    assign wr_enables = wr_en & sel_enables;
    assign wr_inject = wr_en & sel_inject;
    assign wr_control = wr_en & sel_control;
    assign wr_power = wr_en & sel_power;

    ////////////////////////////////////////////////////////////////////////
    // Change detection

    cse_change_detect u_detect (
        .core_clk(core_clk),
        .rst(rst),
        .card_status_change_signal(card_status_change_signal),
        .detect_one_status(detect_one_status),
        .detect_two_status(detect_two_status),
        .power_cycle_status(power_cycle_status),
        .cardbus_card(cardbus_card),
        // RULE8 rearm on card reset exit
        .rearm(card_reset_release),
        .change_pulse(change_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Change flags

    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [3:0] flag_set;

    // RULE7 inject sets flags
    assign inject_set = wr_inject ?
                        (reg_wdata[3:0] & wmask[3:0]) : 4'h0;
    // RULE6 write one clears
    assign w1c_clear = wr_flags ?
                       (reg_wdata[3:0] & wmask[3:0]) : 4'h0;
    // RULE16 set sources ignore enables
    assign flag_set = change_pulse | inject_set;

    always_comb begin
        // Set beats clear in the same cycle
        // RULE5 flags record change only
        flags_d = (flags_q & ~w1c_clear) | flag_set;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_q <= cse_pkg::RST_FLAGS[3:0];
        end else if (bus_clear) begin
            // RULE8 flags cleared by bus reset
            flags_q <= cse_pkg::RST_FLAGS[3:0];
        end else begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables, control and power

    logic [3:0] enables_q;
    logic [31:0] enables_wr;
    logic [31:0] control_q;
    logic [31:0] power_q;

    // Enables live in byte lane 0 only
    assign enables_wr = merge({28'h0000000, enables_q}, reg_wdata, reg_be);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enables_q <= cse_pkg::RST_ENABLES;
        end else if (context_clear) begin
            enables_q <= cse_pkg::RST_ENABLES;
        end else if (wr_enables) begin
            enables_q <= enables_wr[3:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_q <= cse_pkg::RST_CONTROL;
        end else if (context_clear) begin
            control_q <= cse_pkg::RST_CONTROL;
        end else if (wr_control) begin
            control_q <= merge(control_q, reg_wdata, reg_be);
        end
    end

    // RULE3 power control register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_q <= cse_pkg::RST_POWER;
        end else if (context_clear) begin
            power_q <= cse_pkg::RST_POWER;
        end else if (wr_power) begin
            power_q <= merge(power_q, reg_wdata, reg_be);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt

    logic [3:0] armed;
    always_comb begin
        armed = enables_q;
        // RULE17 detect pair needs 11
        if (enables_q[cse_pkg::BIT_CD2:cse_pkg::BIT_CD1] != cse_pkg::DETECT_EN_ON) begin
            armed[cse_pkg::BIT_CD2:cse_pkg::BIT_CD1] = cse_pkg::DETECT_EN_OFF;
        end
    end

    // RULE18 enabled flag raises interrupt
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_change_interrupt <= 1'b0;
        end else begin
            status_change_interrupt <= |(flags_d & armed) & ~bus_clear;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_out <= cse_pkg::RST_CONTROL;
        end else begin
            control_out <= control_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_out <= cse_pkg::RST_POWER;
        end else begin
            power_out <= power_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] state_word;
    logic [31:0] rd_word;

    // RULE5 current state readable
    always_comb begin
        state_word = 32'h0000_0000;
        state_word[cse_pkg::ST_CSTS] = card_status_change_signal;
        state_word[cse_pkg::ST_CD1] = detect_one_status;
        state_word[cse_pkg::ST_CD2] = detect_two_status;
        state_word[cse_pkg::ST_PWR] = power_cycle_status;
        state_word[cse_pkg::ST_16CARD] = pc16_card;
        state_word[cse_pkg::ST_CBCARD] = cardbus_card;
        state_word[cse_pkg::ST_3VSOCK] = 1'b1;
        state_word[cse_pkg::ST_5VSOCK] = 1'b1;
    end

    // RULE2 offset decode
    always_comb begin
        rd_word = 32'h0000_0000;
        if (sel_flags) begin
            // RULE10 upper bits zero
            rd_word = {28'h0000000, flags_q};
        end else if (sel_enables) begin
            rd_word = {28'h0000000, enables_q};
        end else if (sel_state) begin
            rd_word = state_word;
        end else if (sel_control) begin
            rd_word = control_q;
        end else if (sel_power) begin
            rd_word = power_q;
        end else if (sel_inject || sel_rsvd) begin
            // Write-only and reserved offsets read zero
            rd_word = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rd_en ? rd_word : 32'h0000_0000;
        end
    end

    // One acknowledge for every taken access
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= rd_en | wr_en;
        end
    end
endmodule : cse_socket_regs
`default_nettype wire

/* File: test/cse_socket_regs_assertions.sv */
// Port assertions for the socket register bank
`timescale 1ns/100ps
`default_nettype none
module cse_socket_regs_assertions #(
    parameter int ADDR_W = 6
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic global_reset_n,
    input wire logic bus_reset_n,
    input wire logic pme_enable,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_be,
    input wire logic card_status_change_signal,
    input wire logic detect_one_status,
    input wire logic cardbus_card,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic status_change_interrupt
);
    logic [3:0] en_q;
    wire logic run = bus_reset_n && global_reset_n;
    wire logic [3:0] eff = {en_q[3], {2{en_q[2:1] == 2'h3}}, en_q[0]};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of the enable register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_q <= 4'h0;
        end else if (!global_reset_n || (!bus_reset_n && !pme_enable)) begin
            en_q <= 4'h0;
        end else if (reg_sel && reg_wr && reg_be[0] && reg_addr[5:2] == 4'h1) begin
            en_q <= reg_wdata[3:0];
        end
    end
    sequence s_acc;
        reg_sel && (reg_wr || reg_rd);
    endsequence
    sequence s_inj;
        reg_sel && reg_wr && reg_be[0] && reg_wdata[0] && reg_addr[5:2] == 4'h3 && eff[0] && run;
    endsequence
    a_ack_follows: assert property (s_acc |=> reg_ack) else $error("no acknowledge");
    a_idle_rdata: assert property (!(reg_sel && reg_rd) |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    a_rsvd_zero: assert property (reg_sel && reg_rd && reg_addr[5:2] == 4'h0
        |=> reg_rdata[31:4] == 28'h0) else $error("upper flag bits set");
    a_inject_irq: assert property (s_inj |-> ##[1:2] status_change_interrupt)
        else $error("inject raised no interrupt");
    a_reset_quiet: assert property (!run |=> !status_change_interrupt)
        else $error("interrupt during reset");
    a_mask_gate: assert property ((eff == 4'h0) [*2] |-> !status_change_interrupt)
        else $error("interrupt while disabled");
    a_detect_irq: assert property ($changed(detect_one_status) && eff[1] && run
        |-> ##[1:3] status_change_interrupt) else $error("detect change missed");
    a_cb_rise: assert property ($rose(card_status_change_signal) && cardbus_card && eff[0] && run
        |-> ##[1:3] status_change_interrupt) else $error("status rise missed");
endmodule : cse_socket_regs_assertions
bind cse_socket_regs cse_socket_regs_assertions #(.ADDR_W(ADDR_W)) cse_socket_regs_assertions_inst (.*);
`default_nettype wire

/* File: test/cse_card_model.sv */
// Card in the socket, driving status and card type lines
`timescale 1ns/100ps
`default_nettype none
module cse_card_model (
    input wire logic core_clk,
    input wire cse_pkg::cse_card_e kind,
    input wire logic [3:0] lv,
    output logic card_status_change_signal,
    output logic detect_one_status,
    output logic detect_two_status,
    output logic power_cycle_status,
    output logic cardbus_card,
    output logic pc16_card
);
    // Lines follow the requested levels one edge later
    always_ff @(posedge core_clk) begin
        {power_cycle_status, detect_two_status, detect_one_status, card_status_change_signal} <= lv;
        cardbus_card <= kind == cse_pkg::CSE_CARD_CB;
        pc16_card <= kind == cse_pkg::CSE_CARD_16;
    end
endmodule : cse_card_model
`default_nettype wire

/* File: test/cse_socket_regs_tb.sv */
// Self-checking bench for the socket register bank
`timescale 1ns/100ps
`default_nettype none
module cse_socket_regs_tb;
    logic core_clk, rst, global_reset_n, bus_reset_n, pme_enable, card_reset_release;
    logic reg_sel, reg_wr, reg_rd, reg_ack, status_change_interrupt, card_status_change_signal;
    logic detect_one_status, detect_two_status, power_cycle_status, cardbus_card, pc16_card;
    logic [5:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_v, control_out, power_out;
    logic [3:0] reg_be, lv;
    cse_pkg::cse_card_e kind = cse_pkg::CSE_CARD_NONE;
    int n_errors = 0;
    int num_checks = 0;
    cse_socket_regs cse_socket_regs_inst (.*);
    cse_card_model cse_card_model_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic fail(input string m);
        n_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, w, !w, a, d};
        @(posedge core_clk);
        #1;
        {reg_sel, reg_wr, reg_rd} = 3'h0;
        rd_v = reg_rdata;
    endtask : acc
    task automatic chk_reg(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        num_checks++;
        if (rd_v !== e) fail("register value");
    endtask : chk_reg
    task automatic chk_irq(input logic e);
        num_checks++;
        if (status_change_interrupt !== e) fail("interrupt level");
    endtask : chk_irq
    task automatic chk_out(input logic [31:0] v, input logic [31:0] e);
        num_checks++;
        if (v !== e) fail("mirror output");
    endtask : chk_out
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic results;
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        #100000;
        fail("timeout");
        results();
    end
    initial begin
        {rst, global_reset_n, bus_reset_n, pme_enable, card_reset_release} = 5'h1C;
        {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata, reg_be, lv} = {41'h0, 8'hF0};
        cyc(10);
        rst = 1'b0;
        acc(1'b1, 6'h14, '1);
        chk_reg(6'h14, 32'h0);
        acc(1'b1, 6'h20, 32'hA5A5_5A5A);
        chk_reg(6'h20, 32'hA5A5_5A5A);
        chk_out(power_out, 32'hA5A5_5A5A);
        reg_be = 4'h3;
        acc(1'b1, 6'h10, 32'hC3C3_C3C3);
        reg_be = 4'hF;
        chk_reg(6'h10, 32'h0000_C3C3);
        chk_out(control_out, 32'h0000_C3C3);
        acc(1'b1, 6'h0C, '1);
        acc(1'b1, 6'h00, 32'h5);
        chk_reg(6'h00, 32'hA);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 6'h04, 32'(i * 2));
            cyc(1);
            chk_irq(i == 3);
        end
        acc(1'b1, 6'h04, 32'h1);
        acc(1'b1, 6'h0C, 32'h1);
        chk_reg(6'h00, 32'hB);
        chk_irq(1'b1);
        acc(1'b1, 6'h00, '1);
        acc(1'b1, 6'h04, 32'hF);
        for (int j = 0; j < 10; j++) begin
            kind = j < 8 ? cse_pkg::CSE_CARD_CB : cse_pkg::CSE_CARD_16;
            lv[j < 6 ? j / 2 + 1 : 0] = !j[0];
            cyc(4);
            chk_reg(6'h08, {4'h3, 22'h0, kind == cse_pkg::CSE_CARD_CB, !cardbus_card, lv});
            chk_reg(6'h00, j < 6 ? 32'h1 << (j / 2 + 1) : {31'h0, j > 7 || !j[0]});
            acc(1'b1, 6'h00, 32'hF);
        end
        for (int p = 0; p < 3; p++) begin
            pme_enable = p != 1;
            acc(1'b1, 6'h0C, '1);
            acc(1'b1, 6'h04, 32'hF);
            {global_reset_n, bus_reset_n} = p == 2 ? 2'b01 : 2'b10;
            cyc(2);
            {global_reset_n, bus_reset_n} = 2'b11;
            chk_reg(6'h00, 32'h0);
            chk_reg(6'h04, p == 0 ? 32'hF : 32'h0);
            chk_out(power_out, p == 0 ? 32'hA5A5_5A5A : 32'h0);
            chk_out(control_out, p == 0 ? 32'h0000_C3C3 : 32'h0);
        end
        lv[1] = 1'b1;
        cyc(4);
        acc(1'b1, 6'h00, '1);
        card_reset_release = 1'b1;
        cyc(1);
        card_reset_release = 1'b0;
        cyc(4);
        chk_reg(6'h00, 32'h2);
        results();
    end
endmodule : cse_socket_regs_tb
`default_nettype wire
